// ---- rtl/isq_consts.vh ----
// Constants for the input source qualify and status block.
// Assumes one 25 MHz clock; included only by the top design file of the block.
// What this block does
// - Sleep: converter off, battery switches on
// - Leaving sleep starts a new charge cycle
// - Input droop lowers the input current limit
// - On attach, test sink for 32 ms
// - Pass after 32 ms starts the converter
// - Fail: sink off two seconds, retry
// - Weak source in run: converter off, switch on
// - Adapter input qualified before USB input
// - First adapter fail: USB two seconds, retry
// - Second adapter fail locks adapter out
// - Lockout holds until adapter below UVLO
// - Overvoltage: converter off, suspend, switches on
// - Overvoltage clear restores the prior state
// - Reverse current: system target 1 ms, switch off in run
// - After 1 ms re-enable switch, recheck battery
// - Reverse protection armed only in battery window
// - After reverse boost, stop until recharge level
// - Input-valid low only for a valid supply
// - Charge-active low during a new cycle
// - New cycle on battery or power reinsertion
// - Charge-active released on fault or invalid supply
// - No charge-active low during recharge cycles
`ifndef ISQ_CONSTS_VH
`define ISQ_CONSTS_VH
`define ISQ_CLK_HZ 25000000
`define ISQ_TEST_MS 32
`define ISQ_RETRY_MS 2000
`define ISQ_RBOOST_US 1000
`define ISQ_TEST_CYC (`ISQ_CLK_HZ / 1000 * `ISQ_TEST_MS)
`define ISQ_RETRY_CYC (`ISQ_CLK_HZ / 1000 * `ISQ_RETRY_MS)
`define ISQ_RBOOST_CYC (`ISQ_CLK_HZ / 1000000 * `ISQ_RBOOST_US)
`define ISQ_SEL_NONE 2'h0
`define ISQ_SEL_ADP 2'h1
`define ISQ_SEL_USB 2'h2
`define ISQ_CNT_W 26
`endif

// ---- rtl/isq_sync.v ----
// Two-stage synchroniser for a bus of comparator levels.
// Assumes inputs may change at any time relative to the clock.
module isq_sync #(
    parameter WIDTH = 16
) (
    input wire clk,
    input wire ce,
    input wire srst,
    input wire [WIDTH-1:0] d,
    output reg [WIDTH-1:0] q
);
    reg [WIDTH-1:0] meta;

    always @(posedge clk) begin
        if (srst) begin
            meta <= {WIDTH{1'b0}};
            q <= {WIDTH{1'b0}};
        end else if (ce) begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// ---- rtl/isq_timer.v ----
// Load-and-count-down interval timer with a one-cycle done pulse.
// Assumes load and the count value are steady in the load cycle.
module isq_timer #(
    parameter W = 26
) (
    input wire clk,
    input wire ce,
    input wire srst,
    input wire load,
    input wire stop,
    input wire [W-1:0] count,
    output wire busy,
    output reg done
);
    reg [W-1:0] left;

    assign busy = (left != {W{1'b0}});

    always @(posedge clk) begin
        if (srst) begin
            left <= {W{1'b0}};
            done <= 1'b0;
        end else if (ce) begin
            done <= 1'b0;
            if (stop) begin
                left <= {W{1'b0}};
            end else if (load) begin
                left <= count;
            end else if (busy) begin
                left <= left - {{(W-1){1'b0}}, 1'b1};
                done <= (left == {{(W-1){1'b0}}, 1'b1});
            end
        end
    end
endmodule

// ---- rtl/isq_top.v ----
// Input source qualification, power-path control and status outputs.
// Assumes comparator results arrive as asynchronous digital levels;
// open-drain status pins are resolved outside from their enables.
`include "isq_consts.vh"
module isq_top #(
    parameter TEST_CYC = `ISQ_TEST_CYC,
    parameter RETRY_CYC = `ISQ_RETRY_CYC,
    parameter RBOOST_CYC = `ISQ_RBOOST_CYC
) (
    // Clock, reset, enable
    input wire SYS_CLK,
    input wire SRST,
    input wire CE,
    // Adapter input comparators
    input wire ADP_ABOVE_UVLO,
    input wire ADP_ABOVE_SLEEP,
    input wire ADP_ABOVE_OVP,
    input wire ADP_ABOVE_WEAK_HI,
    input wire ADP_ABOVE_WEAK_LO,
    // USB input comparators
    input wire USB_ABOVE_UVLO,
    input wire USB_ABOVE_SLEEP,
    input wire USB_ABOVE_OVP,
    input wire USB_ABOVE_WEAK_HI,
    input wire USB_ABOVE_WEAK_LO,
    // Battery and converter sense
    input wire INPUT_DROOP_SENSE,
    input wire REVERSE_CURRENT,
    input wire SUPPLEMENT_TRIP,
    input wire BAT_BELOW_OVERVOLTAGE,
    input wire BAT_ABOVE_RECHARGE,
    input wire BAT_PRESENT,
    input wire CHARGE_TERMINATED,
    input wire TIMER_FAULT,
    // Power path control
    output reg CONVERTER_EN,
    output reg BATTERY_SWITCH,
    output reg EXT_BATTERY_SWITCH_GATE,
    output reg INPUT_LIMIT_REDUCE,
    output reg ADP_TEST_SINK_EN,
    output reg USB_TEST_SINK_EN,
    output reg USE_USB_INPUT,
    output reg SYSTEM_RAIL_FEEDBACK,
    output reg CHARGE_EN,
    output reg ADP_LOCKED_OUT,
    // Open-drain status pins, enable high pulls low
    output reg INPUT_VALID_N_OE,
    output reg CHARGE_ACTIVE_N_OE,
    output reg INPUT_VALID_N_O,
    output reg CHARGE_ACTIVE_N_O
);
    // Qualification policy: the adapter is tested first. With USB present,
    // its first failure runs from USB for one retry interval and its second
    // locks it out. A lone source that fails simply rests and retests, so a
    // slow supply ramp never locks out the only input there is.
    // Over-voltage keeps the state that it interrupted, so that it resumes
    // there; a supply that falls below UVLO restarts from idle, except in the wait, which moves to testing the other input if it is up.
    localparam ST_IDLE = 3'h0;
    localparam ST_TEST = 3'h1;
    localparam ST_WAIT = 3'h2;
    localparam ST_RUN = 3'h3;
    localparam ST_SLEEP = 3'h4;
    localparam ST_OVP = 3'h5;

    wire [17:0] sync_q;
    wire a_uvlo, a_slp, a_ovp, a_whi, a_wlo;
    wire u_uvlo, u_slp, u_ovp, u_whi, u_wlo;
    wire droop, rev, supp, bat_ok_hi, bat_rch, bat_in, term, tfault;

    isq_sync #(.WIDTH(18)) u_sync (
        .clk(SYS_CLK),
        .ce(CE),
        .srst(SRST),
        .d({ADP_ABOVE_UVLO, ADP_ABOVE_SLEEP, ADP_ABOVE_OVP,
            ADP_ABOVE_WEAK_HI, ADP_ABOVE_WEAK_LO,
            USB_ABOVE_UVLO, USB_ABOVE_SLEEP, USB_ABOVE_OVP,
            USB_ABOVE_WEAK_HI, USB_ABOVE_WEAK_LO,
            INPUT_DROOP_SENSE, REVERSE_CURRENT, SUPPLEMENT_TRIP,
            BAT_BELOW_OVERVOLTAGE, BAT_ABOVE_RECHARGE, BAT_PRESENT,
            CHARGE_TERMINATED, TIMER_FAULT}),
        .q(sync_q)
    );
    assign {a_uvlo, a_slp, a_ovp, a_whi, a_wlo,
            u_uvlo, u_slp, u_ovp, u_whi, u_wlo,
            droop, rev, supp, bat_ok_hi, bat_rch, bat_in,
            term, tfault} = sync_q;

    reg [2:0] state, next_state, saved;
    reg [1:0] sel, next_sel;
    reg adp_fails, next_adp_fails;
    reg locked, next_locked;
    reg usb_trial, next_usb_trial;
    reg rb_hold;
    reg bat_in_d;
    reg new_cycle;

    // The selected input's comparators
    wire s_uvlo = (sel == `ISQ_SEL_USB) ? u_uvlo : a_uvlo;
    wire s_slp = (sel == `ISQ_SEL_USB) ? u_slp : a_slp;
    wire s_ovp = (sel == `ISQ_SEL_USB) ? u_ovp : a_ovp;
    wire s_whi = (sel == `ISQ_SEL_USB) ? u_whi : a_whi;
    wire s_wlo = (sel == `ISQ_SEL_USB) ? u_wlo : a_wlo;
    wire adp_ok = a_uvlo & ~locked;
    wire s_valid = s_uvlo & s_slp & ~s_ovp;
    // The valid pin reports either input, whether or not it is selected
    wire a_valid = a_uvlo & a_slp & ~a_ovp;
    wire u_valid = u_uvlo & u_slp & ~u_ovp;

    reg t_load, r_load, t_stop, r_stop;
    wire t_busy, t_done, r_busy, r_done;
    wire rb_busy_w, rb_done;
    wire rb_load = CE & rev & ~supp & bat_ok_hi & bat_rch & ~rb_busy_w;
    // Collapse below the low threshold, or no high threshold at the end
    wire test_fail = !s_wlo || (t_done && !s_whi);

    isq_timer #(.W(`ISQ_CNT_W)) u_test_tmr (
        .clk(SYS_CLK),
        .ce(CE),
        .srst(SRST),
        .load(t_load),
        .stop(t_stop),
        .count(r_load ? RETRY_CYC[`ISQ_CNT_W-1:0]
                      : TEST_CYC[`ISQ_CNT_W-1:0]),
        .busy(t_busy),
        .done(t_done)
    );

    isq_timer #(.W(`ISQ_CNT_W)) u_rb_tmr (
        .clk(SYS_CLK),
        .ce(CE),
        .srst(SRST),
        .load(rb_load),
        .stop(1'b0),
        .count(RBOOST_CYC[`ISQ_CNT_W-1:0]),
        .busy(rb_busy_w),
        .done(rb_done)
    );

    // One timer serves the test and the wait; r_load picks the length
    always @* begin
        next_state = state;
        next_sel = sel;
        next_adp_fails = adp_fails;
        next_locked = locked;
        next_usb_trial = usb_trial;
        t_load = 1'b0;
        r_load = 1'b0;
        t_stop = 1'b0;
        r_stop = 1'b0;
        if (!a_uvlo) begin
            // Removing the adapter forgets its failures and its lockout
            next_locked = 1'b0;
            next_adp_fails = 1'b0;
        end
        case (state)
        ST_IDLE: begin
            if (adp_ok) begin
                next_sel = `ISQ_SEL_ADP;
                next_state = ST_TEST;
                t_load = 1'b1;
            end else if (u_uvlo) begin
                next_sel = `ISQ_SEL_USB;
                next_state = ST_TEST;
                t_load = 1'b1;
            end else begin
                next_sel = `ISQ_SEL_NONE;
            end
        end
        ST_TEST: begin
            if (!s_uvlo) begin
                next_state = ST_IDLE;
                t_stop = 1'b1;
            end else if (test_fail) begin
                if (sel == `ISQ_SEL_ADP && u_uvlo) begin
                    if (adp_fails) begin
                        next_locked = 1'b1;
                        next_sel = `ISQ_SEL_USB;
                        next_state = ST_TEST;
                        t_load = 1'b1;
                    end else begin
                        next_adp_fails = 1'b1;
                        next_sel = `ISQ_SEL_USB;
                        next_usb_trial = 1'b1;
                        next_state = ST_RUN;
                        t_load = 1'b1;
                        r_load = 1'b1;
                    end
                end else begin
                    next_state = ST_WAIT;
                    t_load = 1'b1;
                    r_load = 1'b1;
                end
            end else if (t_done) begin
                next_state = ST_RUN;
            end
        end
        ST_WAIT: begin
            if (sel == `ISQ_SEL_USB && adp_ok) begin
                next_sel = `ISQ_SEL_ADP;
                next_state = ST_TEST;
                t_load = 1'b1;
            end else if (sel == `ISQ_SEL_ADP && !adp_ok && u_uvlo) begin
                next_sel = `ISQ_SEL_USB;
                next_state = ST_TEST;
                t_load = 1'b1;
            end else if (!s_uvlo) begin
                next_state = ST_IDLE;
                t_stop = 1'b1;
            end else if (t_done) begin
                next_state = ST_TEST;
                t_load = 1'b1;
            end
        end
        ST_RUN: begin
            if (!s_uvlo) begin
                next_state = ST_IDLE;
                next_usb_trial = 1'b0;
            end else if (s_ovp) begin
                next_state = ST_OVP;
            end else if (!s_slp) begin
                next_state = ST_SLEEP;
            end else if (!s_wlo) begin
                next_state = ST_TEST;
                t_load = 1'b1;
            end else if (usb_trial && !t_busy) begin
                next_usb_trial = 1'b0;
                next_sel = `ISQ_SEL_ADP;
                next_state = ST_TEST;
                t_load = 1'b1;
            end else if (usb_trial && !adp_ok) begin
                next_usb_trial = 1'b0;
                t_stop = 1'b1;
            end else if (sel == `ISQ_SEL_USB && !usb_trial && adp_ok) begin
                // A newly attached adapter takes over once it passes
                next_sel = `ISQ_SEL_ADP;
                next_state = ST_TEST;
                t_load = 1'b1;
            end
        end
        ST_SLEEP: begin
            if (!s_uvlo) begin
                next_state = ST_IDLE;
            end else if (s_ovp) begin
                next_state = ST_OVP;
            end else if (s_slp) begin
                next_state = ST_RUN;
            end
        end
        ST_OVP: begin
            if (!s_uvlo) begin
                next_state = ST_IDLE;
            end else if (!s_ovp) begin
                next_state = saved;
            end
        end
        default: begin
            next_state = ST_IDLE;
        end
        endcase
    end

    always @(posedge SYS_CLK) begin
        if (SRST) begin
            state <= ST_IDLE;
            saved <= ST_IDLE;
            sel <= `ISQ_SEL_NONE;
            adp_fails <= 1'b0;
            locked <= 1'b0;
            usb_trial <= 1'b0;
            rb_hold <= 1'b0;
            bat_in_d <= 1'b0;
            new_cycle <= 1'b0;
        end else if (CE) begin
            state <= next_state;
            sel <= next_sel;
            adp_fails <= next_adp_fails;
            locked <= next_locked;
            usb_trial <= next_usb_trial;
            bat_in_d <= bat_in;
            if (next_state == ST_OVP && state != ST_OVP) begin
                saved <= state;
            end
            if (rb_done) begin
                rb_hold <= 1'b1;
            end else if (!bat_rch) begin
                rb_hold <= 1'b0;
            end
            // Power return or battery insertion opens a new cycle
            // No battery, no cycle: the pin must not blink on an empty slot
            if ((state != ST_RUN && next_state == ST_RUN
                 && state != ST_OVP && bat_in)
                || (bat_in && !bat_in_d)) begin
                new_cycle <= 1'b1;
            end else if (term || tfault || !bat_in || !s_valid) begin
                new_cycle <= 1'b0;
            end
        end
    end

    // Outputs are registered; they lag the state by one cycle
    always @(posedge SYS_CLK) begin
        if (SRST) begin
            CONVERTER_EN <= 1'b0;
            BATTERY_SWITCH <= 1'b1;
            EXT_BATTERY_SWITCH_GATE <= 1'b1;
            INPUT_LIMIT_REDUCE <= 1'b0;
            ADP_TEST_SINK_EN <= 1'b0;
            USB_TEST_SINK_EN <= 1'b0;
            USE_USB_INPUT <= 1'b0;
            SYSTEM_RAIL_FEEDBACK <= 1'b0;
            CHARGE_EN <= 1'b0;
            ADP_LOCKED_OUT <= 1'b0;
            INPUT_VALID_N_OE <= 1'b0;
            CHARGE_ACTIVE_N_OE <= 1'b0;
            INPUT_VALID_N_O <= 1'b0;
            CHARGE_ACTIVE_N_O <= 1'b0;
        end else if (CE) begin
            CONVERTER_EN <= (state == ST_RUN);
            // In run, reverse boost holds the switch off for the interval
            BATTERY_SWITCH <= (state != ST_RUN) || !rb_busy_w;
            EXT_BATTERY_SWITCH_GATE <= (state == ST_SLEEP)
                || (state == ST_OVP) || (state == ST_IDLE);
            INPUT_LIMIT_REDUCE <= (state == ST_RUN) && droop;
            ADP_TEST_SINK_EN <= (state == ST_TEST)
                && (sel == `ISQ_SEL_ADP);
            USB_TEST_SINK_EN <= (state == ST_TEST)
                && (sel == `ISQ_SEL_USB);
            USE_USB_INPUT <= (sel == `ISQ_SEL_USB);
            SYSTEM_RAIL_FEEDBACK <= rb_busy_w;
            CHARGE_EN <= (state == ST_RUN) && !rb_busy_w
                && !rb_hold && bat_in;
            ADP_LOCKED_OUT <= locked;
            INPUT_VALID_N_OE <= a_valid | u_valid;
            CHARGE_ACTIVE_N_OE <= new_cycle && s_valid;
        end
    end
endmodule

// ---- testbench/isq_supply_model.sv ----
// Far side of the qualify block: supplies become comparator results,
// and the two open-drain status pins are resolved against pull-ups.
module isq_supply_model (
    // Supply levels: 0 absent, 1 sleep, 2 collapsed, 3 weak, 4 good, 5 over
    input logic [2:0] adp_lvl,
    input logic [2:0] usb_lvl,
    // Comparator results {uvlo, sleep, ovp, weak_hi, weak_lo}
    output logic [4:0] adp_cmp,
    output logic [4:0] usb_cmp,
    // Status pins
    input logic valid_oe,
    input logic chg_oe,
    output logic input_valid_n,
    output logic charge_active_n
);
    timeunit 1ns;
    timeprecision 100ps;
    function automatic logic [4:0] cmp(input logic [2:0] l);
        return {l >= 3'h1, l >= 3'h2, l == 3'h5, l >= 3'h4, l >= 3'h3};
    endfunction
    assign adp_cmp = cmp(adp_lvl);
    assign usb_cmp = cmp(usb_lvl);
    // Pull-ups set the level whenever the device lets go of a pin
    assign input_valid_n = valid_oe ? 1'h0 : 1'h1;
    assign charge_active_n = chg_oe ? 1'h0 : 1'h1;
endmodule

// ---- testbench/isq_top_asserts.sv ----
// Checker for the qualify block, bound to its top; sees only its ports.
// Assumes CE is held high, so the run-length counters need no enable.
module isq_top_asserts #(
    parameter TEST_CYC = 20,
    parameter RBOOST_CYC = 10
) (
    // Clock and reset
    input wire SYS_CLK,
    input wire SRST,
    // Supply comparators
    input wire ADP_ABOVE_UVLO,
    input wire ADP_ABOVE_SLEEP,
    input wire ADP_ABOVE_OVP,
    input wire USB_ABOVE_UVLO,
    input wire USB_ABOVE_SLEEP,
    input wire USB_ABOVE_OVP,
    // Battery and sense
    input wire INPUT_DROOP_SENSE,
    input wire REVERSE_CURRENT,
    input wire SUPPLEMENT_TRIP,
    input wire BAT_BELOW_OVERVOLTAGE,
    input wire BAT_ABOVE_RECHARGE,
    input wire BAT_PRESENT,
    // Watched outputs
    input wire CONVERTER_EN,
    input wire EXT_BATTERY_SWITCH_GATE,
    input wire INPUT_LIMIT_REDUCE,
    input wire ADP_TEST_SINK_EN,
    input wire SYSTEM_RAIL_FEEDBACK,
    input wire ADP_LOCKED_OUT,
    input wire INPUT_VALID_N_OE,
    input wire CHARGE_ACTIVE_N_OE
);
    logic ok_valid;
    logic [31:0] sink_cnt;
    logic [31:0] rb_cnt;
    assign ok_valid = (ADP_ABOVE_UVLO && ADP_ABOVE_SLEEP && !ADP_ABOVE_OVP)
        || (USB_ABOVE_UVLO && USB_ABOVE_SLEEP && !USB_ABOVE_OVP);
    // Run lengths; asserting on counters avoids long repetitions
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            sink_cnt <= 32'h0;
            rb_cnt <= 32'h0;
        end else begin
            sink_cnt <= ADP_TEST_SINK_EN ? sink_cnt + 32'h1 : 32'h0;
            rb_cnt <= SYSTEM_RAIL_FEEDBACK ? rb_cnt + 32'h1 : 32'h0;
        end
    end
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SRST);
    sequence s_rev_armed;
        (REVERSE_CURRENT && !SUPPLEMENT_TRIP && BAT_BELOW_OVERVOLTAGE
            && BAT_ABOVE_RECHARGE) [*4];
    endsequence
    sequence s_below_rech;
        (!BAT_ABOVE_RECHARGE) [*5];
    endsequence
    a_conv_gate_excl: assert property (
        !(CONVERTER_EN && EXT_BATTERY_SWITCH_GATE)) else $error("gate on");
    a_droop_reduce: assert property (
        (INPUT_DROOP_SENSE && CONVERTER_EN) [*5] |-> INPUT_LIMIT_REDUCE)
        else $error("limit not reduced");
    a_sink_bound: assert property (sink_cnt <= TEST_CYC + 3)
        else $error("test sink too long");
    a_lock_holds: assert property (
        (ADP_LOCKED_OUT && ADP_ABOVE_UVLO) [*4] |=> ADP_LOCKED_OUT)
        else $error("lockout dropped");
    a_lock_clears: assert property (
        (!ADP_ABOVE_UVLO) [*5] |-> !ADP_LOCKED_OUT)
        else $error("lockout stuck");
    a_rboost_arms: assert property (
        s_rev_armed |-> ##[0:3] SYSTEM_RAIL_FEEDBACK)
        else $error("reverse boost missed");
    a_rboost_window: assert property (
        s_below_rech |-> !$rose(SYSTEM_RAIL_FEEDBACK))
        else $error("reverse boost outside window");
    a_rboost_max: assert property (
        SYSTEM_RAIL_FEEDBACK |-> rb_cnt <= RBOOST_CYC + 1)
        else $error("reverse interval long");
    a_rboost_full: assert property (
        $fell(SYSTEM_RAIL_FEEDBACK) |-> rb_cnt >= RBOOST_CYC - 1)
        else $error("reverse interval short");
    a_valid_low: assert property (ok_valid [*6] |-> INPUT_VALID_N_OE)
        else $error("valid pin not low");
    a_valid_rel: assert property ((!ok_valid) [*6] |-> !INPUT_VALID_N_OE)
        else $error("valid pin held");
    a_chg_nobat: assert property (
        (!BAT_PRESENT) [*5] |-> !CHARGE_ACTIVE_N_OE)
        else $error("charge pin low without battery");
endmodule
bind isq_top isq_top_asserts #(
    .TEST_CYC(TEST_CYC),
    .RBOOST_CYC(RBOOST_CYC)
) i_isq_top_asserts (
    .SYS_CLK, .SRST, .ADP_ABOVE_UVLO, .ADP_ABOVE_SLEEP, .ADP_ABOVE_OVP,
    .USB_ABOVE_UVLO, .USB_ABOVE_SLEEP, .USB_ABOVE_OVP, .INPUT_DROOP_SENSE,
    .REVERSE_CURRENT, .SUPPLEMENT_TRIP, .BAT_BELOW_OVERVOLTAGE,
    .BAT_ABOVE_RECHARGE, .BAT_PRESENT, .CONVERTER_EN,
    .EXT_BATTERY_SWITCH_GATE, .INPUT_LIMIT_REDUCE, .ADP_TEST_SINK_EN,
    .SYSTEM_RAIL_FEEDBACK, .ADP_LOCKED_OUT, .INPUT_VALID_N_OE,
    .CHARGE_ACTIVE_N_OE
);

// ---- testbench/isq_top_tb.sv ----
// Self-checking bench for the input qualify block.
// Assumes short interval parameters so retries fit in a short run.
module isq_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int TC = 20;
    localparam int RC = 60;
    localparam int RB = 10;
    typedef struct packed {
        logic [2:0] adp;
        logic droop;
        logic [7:0] cyc;
        logic [5:0] exp;
    } isq_row_t;
    // Expect {converter, gate, reduce, valid pin, adapter sink, charge pin}
    isq_row_t rows [9] = '{
        '{3'h0, 1'h0, 8'h0A, 6'h15}, '{3'h4, 1'h0, 8'h08, 6'h03},
        '{3'h4, 1'h0, 8'h14, 6'h20}, '{3'h5, 1'h0, 8'h08, 6'h15},
        '{3'h4, 1'h0, 8'h08, 6'h21}, '{3'h1, 1'h0, 8'h08, 6'h15},
        '{3'h4, 1'h0, 8'h20, 6'h20}, '{3'h4, 1'h1, 8'h06, 6'h28},
        '{3'h0, 1'h0, 8'h08, 6'h15}
    };
    logic sys_clk;
    logic srst, droop, rev, supp, bat_rech, bat_present, term, tfault;
    logic bat_ovok;
    logic [2:0] adp_lvl, usb_lvl;
    logic [4:0] adp_cmp, usb_cmp;
    wire conv, gate, bsw, reduce, asink, usink, use_usb, sysfb;
    wire chg_en, locked, vld_oe, chg_oe, vld_n, chg_n;
    int num_errors = 0;
    int compares = 0;
    int k;
    isq_top #(.TEST_CYC(TC), .RETRY_CYC(RC), .RBOOST_CYC(RB)) i_isq_top (
        .SYS_CLK(sys_clk), .SRST(srst), .CE(1'h1),
        .ADP_ABOVE_UVLO(adp_cmp[4]), .ADP_ABOVE_SLEEP(adp_cmp[3]),
        .ADP_ABOVE_OVP(adp_cmp[2]), .ADP_ABOVE_WEAK_HI(adp_cmp[1]),
        .ADP_ABOVE_WEAK_LO(adp_cmp[0]), .USB_ABOVE_UVLO(usb_cmp[4]),
        .USB_ABOVE_SLEEP(usb_cmp[3]), .USB_ABOVE_OVP(usb_cmp[2]),
        .USB_ABOVE_WEAK_HI(usb_cmp[1]), .USB_ABOVE_WEAK_LO(usb_cmp[0]),
        .INPUT_DROOP_SENSE(droop), .REVERSE_CURRENT(rev),
        .SUPPLEMENT_TRIP(supp), .BAT_BELOW_OVERVOLTAGE(bat_ovok),
        .BAT_ABOVE_RECHARGE(bat_rech), .BAT_PRESENT(bat_present),
        .CHARGE_TERMINATED(term), .TIMER_FAULT(tfault),
        .CONVERTER_EN(conv), .BATTERY_SWITCH(bsw),
        .EXT_BATTERY_SWITCH_GATE(gate), .INPUT_LIMIT_REDUCE(reduce),
        .ADP_TEST_SINK_EN(asink), .USB_TEST_SINK_EN(usink),
        .USE_USB_INPUT(use_usb), .SYSTEM_RAIL_FEEDBACK(sysfb),
        .CHARGE_EN(chg_en), .ADP_LOCKED_OUT(locked),
        .INPUT_VALID_N_OE(vld_oe), .CHARGE_ACTIVE_N_OE(chg_oe),
        .INPUT_VALID_N_O(), .CHARGE_ACTIVE_N_O()
    );
    isq_supply_model i_isq_supply_model (
        .adp_lvl(adp_lvl), .usb_lvl(usb_lvl), .adp_cmp(adp_cmp),
        .usb_cmp(usb_cmp), .valid_oe(vld_oe), .chg_oe(chg_oe),
        .input_valid_n(vld_n), .charge_active_n(chg_n)
    );
    initial begin
        sys_clk = 1'h0;
        forever #20 sys_clk = ~sys_clk;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t flag got %b want %b", $time, got, exp);
        end
    endtask
    task automatic chk_vec(input logic [5:0] got, input logic [5:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t outputs got %b want %b", $time, got, exp);
        end
    endtask
    task automatic conclude;
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge sys_clk);
        num_errors++;
        conclude();
    end
    initial begin
        {srst, droop, rev, supp, term, tfault} = 6'h20;
        {bat_rech, bat_present} = 2'h3;
        bat_ovok = 1'h1;
        {adp_lvl, usb_lvl} = 6'h00;
        wt(8);
        srst = 1'h0;
        foreach (rows[i]) begin
            adp_lvl = rows[i].adp;
            droop = rows[i].droop;
            wt(int'(rows[i].cyc));
            chk_vec({conv, gate, reduce, vld_n, asink, chg_n}, rows[i].exp);
        end
        // A weak source fails, rests with the sink off, then retests
        adp_lvl = 3'h3;
        wt(6);
        chk(asink, 1'h1);
        wt(TC + 2);
        chk(asink | conv, 1'h0);
        wt(RC - 10);
        chk(asink, 1'h0);
        for (k = 0; k < 30 && asink !== 1'h1; k++) wt(1);
        chk(asink, 1'h1);
        adp_lvl = 3'h2;
        wt(5);
        chk(asink, 1'h0);
        adp_lvl = 3'h0;
        wt(8);
        // Both supplies: adapter first, fallback, retry, then lockout
        {adp_lvl, usb_lvl} = {3'h3, 3'h4};
        wt(6);
        chk(asink & !usink, 1'h1);
        wt(2 * TC + 8);
        chk(use_usb & conv, 1'h1);
        for (k = 0; k < RC + TC + 40 && asink !== 1'h1; k++) wt(1);
        chk(asink, 1'h1);
        wt(TC + 4);
        chk(locked & use_usb, 1'h1);
        wt(RC + TC);
        chk(locked & !asink, 1'h1);
        adp_lvl = 3'h0;
        wt(6);
        chk(locked, 1'h0);
        adp_lvl = 3'h4;
        for (k = 0; k < 80 && !(conv === 1'h1 && use_usb === 1'h0); k++) wt(1);
        chk(use_usb, 1'h0);
        // Reverse boost, suppressed when the supplement path caused it
        {rev, supp} = 2'h3;
        wt(8);
        chk(sysfb, 1'h0);
        chk(chg_en, 1'h1);
        supp = 1'h0;
        wt(5);
        chk(sysfb | bsw, 1'h1);
        chk(bsw, 1'h0);
        rev = 1'h0;
        wt(RB + 2);
        chk(!sysfb & bsw, 1'h1);
        chk(chg_en, 1'h0);
        bat_rech = 1'h0;
        wt(6);
        chk(chg_en, 1'h1);
        rev = 1'h1;
        wt(8);
        chk(sysfb, 1'h0);
        {rev, bat_rech} = 2'h1;
        wt(6);
        {rev, bat_ovok} = 2'h2;
        wt(8);
        chk(sysfb, 1'h0);
        {rev, bat_ovok} = 2'h1;
        // Charge pin across battery swaps, termination and faults
        bat_present = 1'h0;
        wt(6);
        chk(chg_n, 1'h1);
        bat_present = 1'h1;
        wt(6);
        chk(chg_n, 1'h0);
        term = 1'h1;
        wt(6);
        chk(chg_n, 1'h1);
        term = 1'h0;
        wt(6);
        chk(chg_n, 1'h1);
        bat_present = 1'h0;
        wt(6);
        bat_present = 1'h1;
        wt(6);
        chk(chg_n, 1'h0);
        tfault = 1'h1;
        wt(6);
        chk(chg_n, 1'h1);
        // Reset in mid-run returns the power path to its safe state
        srst = 1'h1;
        wt(2);
        chk(gate & bsw & !conv, 1'h1);
        srst = 1'h0;
        wt(2);
        chk(gate & !conv & !sysfb, 1'h1);
        conclude();
    end
endmodule
